// >>> design/bmc_defines.vh
// Overview of operation
// R1: Config bit 7 turns supply-drop detection on (1) or off (0).
// R2: Config bits 6:5 pick one of four drop thresholds.
// R3: Config bit 4 decides whether a drop causes a chip reset.
// R4: After every reset, control bits 7 and 4 load from config bits 7, 4.
// R5: Control bit 7 enables detection at run time.
// R6: Control bit 4 set means a drop below threshold resets the chip.
// R7: Crossing flag bit 3 sets on any fall below or rise above threshold.
// R8: Flag raises interrupt only with monitor and global enables both set.
// R9: Hardware never clears the crossing flag; software writes zero. The code also clears it on reset and while detection is off.
// R10: Low-power sampling select matters only while detection is enabled.
// R11: Low-power mode samples comparator every 12.8ms off a 10kHz tick.
// R12: Status bit 0 is read-only, zero when disabled, else one when below.
// R13: Cold-start flag sets on power-on, survives all other resets.
// R14: Software should clear the cold-start flag to tell cold from warm.
// R15: Software should clear a crossing flag found set after reset.
// R16: Thresholds are 2.2V, 2.7V, 3.8V and 4.5V by select code.
// R17: Flag cleared while still below stays clear until a new crossing.
// R18: With detection disabled, flag and status stay zero.
// R19: Drop reset sets reset-cause flag; only power-on or software alter it.
// R20: Comparator output is synchronised before any logic uses it.
`ifndef BMC_DEFINES_VH
`define BMC_DEFINES_VH
`define BMC_ADDR_POWER_CONTROL_W 8'h87
`define BMC_ADDR_PMC_W 8'hac
`define BMC_ADDR_CFG 8'hb0
`define BMC_ADDR_RCR 8'hb1
`define BMC_ADDR_IEN 8'hb2
`define BMC_CFG_RESET 8'hff
`define BMC_BIT_DET_EN 7
`define BMC_BIT_THR_HI 6
`define BMC_BIT_THR_LO 5
`define BMC_BIT_RST_EN 4
`define BMC_BIT_FLAG 3
`define BMC_BIT_LP 2
`define BMC_BIT_STATUS 0
`define BMC_BIT_COLD 4
`define BMC_BIT_RCAUSE 2
`define BMC_BIT_MON_IE 2
`define BMC_BIT_GLB_IE 7
`define BMC_CLK_HZ 10000000
`define BMC_LP_INTERVAL_US 12800
`define BMC_LP_OSC_HZ 10000
`define BMC_LP_TICK_CYCLES (`BMC_CLK_HZ / `BMC_LP_OSC_HZ)
`define BMC_LP_TICKS (`BMC_LP_INTERVAL_US * `BMC_LP_OSC_HZ / 1000000)
`endif

// >>> design/bmc_sync2.v
`timescale 1ns/1ps
`default_nettype none
module bmc_sync2 (
    input wire clk,
    input wire nrst,
    input wire d,
    output wire q
);
    reg s1_r;
    reg s2_r;
    // Two stages; first stage feeds only the second
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
        end
        else
        begin
            s1_r <= d;
            s2_r <= s1_r;
        end
    end
    assign q = s2_r;
endmodule // bmc_sync2
`default_nettype wire

// >>> design/bmc_lp_timer.v
`timescale 1ns/1ps
`default_nettype none
module bmc_lp_timer #(
    parameter TICK_CYCLES = 1000,
    parameter TICKS = 128
) (
    input wire clk,
    input wire nrst,
    input wire run,
    output reg sample_r
);
    reg [15:0] pre_r;
    reg [15:0] tick_r;
    // Prescaler models the slow oscillator, second counter the interval
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pre_r <= 16'h0000;
            tick_r <= 16'h0000;
            sample_r <= 1'b0;
        end
        else if (!run)
        begin
            pre_r <= 16'h0000;
            tick_r <= 16'h0000;
            sample_r <= 1'b0;
        end
        else
        begin
            sample_r <= 1'b0;
            if (pre_r == TICK_CYCLES[15:0] - 16'h0001)
            begin
                pre_r <= 16'h0000;
                if (tick_r == TICKS[15:0] - 16'h0001)
                begin
                    tick_r <= 16'h0000;
                    sample_r <= 1'b1;
                end
                else
                    tick_r <= tick_r + 16'h0001;
            end
            else
                pre_r <= pre_r + 16'h0001;
        end
    end
endmodule // bmc_lp_timer
`default_nettype wire

// >>> design/bmc_top.v
`timescale 1ns/1ps
`default_nettype none
`include "bmc_defines.vh"
module bmc_top #(
    parameter LP_TICK_CYCLES = `BMC_LP_TICK_CYCLES,
    parameter LP_TICKS = `BMC_LP_TICKS
) (
    input wire clk,
    input wire nrst,
    input wire por_n,
    input wire [7:0] addr,
    input wire [7:0] wdata,
    input wire wr,
    input wire rd,
    output reg [7:0] rdata,
    input wire cmp_below,
    output wire [1:0] threshold_sel,
    output wire cmp_enable,
    output wire lp_osc_enable,
    output wire irq,
    output reg drop_reset_r
);
    // Config word lives across all resets except power-on
    reg [7:0] cfg_r;
    reg cold_start_flag_r;
    reg drop_reset_cause_flag_r;
    reg detect_enable_r;
    reg drop_reset_enable_r;
    reg crossing_flag_r;
    reg low_power_sampling_enable_r;
    reg supply_monitor_irq_enable_r;
    reg global_irq_enable_r;
    reg below_r;
    reg pending_cause_r;
    reg loaded_r;
    wire below_sync;
    wire sample;
    wire lp_active;
    wire detect_on;
    wire sense;
    wire fell;
    wire rose;
    wire wr_pmc;

    // Analog comparator output is asynchronous
    bmc_sync2 u_sync (
        .clk(clk),
        .nrst(nrst),
        .d(cmp_below),
        .q(below_sync)
    ); // see R20

    assign lp_active = detect_enable_r & low_power_sampling_enable_r; // see R10

    bmc_lp_timer #(
        .TICK_CYCLES(LP_TICK_CYCLES),
        .TICKS(LP_TICKS)
    ) u_lp (
        .clk(clk),
        .nrst(nrst),
        .run(lp_active),
        .sample_r(sample)
    ); // see R11

    // Comparator runs only while enabled; low-power mode loses hysteresis
    assign detect_on = detect_enable_r; // see R1
    assign cmp_enable = detect_on; // see R5
    assign lp_osc_enable = lp_active; // see R11
    // Code 00/01/10/11 selects 2.2/2.7/3.8/4.5 V
    assign threshold_sel = {cfg_r[`BMC_BIT_THR_HI],
                            cfg_r[`BMC_BIT_THR_LO]}; // see R2, R16
    // Sample only on the interval strobe in low-power mode
    assign sense = lp_active ? sample : detect_on; // see R11

    // Crossings relative to the last sensed level
    assign fell = sense & below_sync & ~below_r; // see R7
    assign rose = sense & ~below_sync & below_r; // see R7
    assign wr_pmc = wr && (addr == `BMC_ADDR_PMC_W);

    // Sensed supply level; reads zero while disabled
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            below_r <= 1'b0;
        else if (!detect_on)
            below_r <= 1'b0; // see R18
        else if (sense)
            below_r <= below_sync; // see R12
    end

    // Non-volatile configuration only returns to blank on power-on
    always @(posedge clk or negedge por_n)
    begin
        if (!por_n)
            cfg_r <= `BMC_CFG_RESET;
        else if (wr && (addr == `BMC_ADDR_CFG))
            cfg_r <= {wdata[7:4], 4'hf};
    end

    // Flags that survive warm resets
    always @(posedge clk or negedge por_n)
    begin
        if (!por_n)
        begin
            cold_start_flag_r <= 1'b1; // see R13
            drop_reset_cause_flag_r <= 1'b0;
        end
        else
        begin
            if (wr && (addr == `BMC_ADDR_POWER_CONTROL_W))
                cold_start_flag_r <= wdata[`BMC_BIT_COLD]; // see R14
            // Hardware set wins over software write
            if (pending_cause_r)
                drop_reset_cause_flag_r <= 1'b1; // see R19
            else if (wr && (addr == `BMC_ADDR_RCR))
                drop_reset_cause_flag_r <= wdata[`BMC_BIT_RCAUSE];
        end
    end

    // Run-time control: bits 7 and 4 reloaded from config on every reset, the other enables cleared
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            detect_enable_r <= 1'b0;
            drop_reset_enable_r <= 1'b0;
            low_power_sampling_enable_r <= 1'b0;
            supply_monitor_irq_enable_r <= 1'b0;
            global_irq_enable_r <= 1'b0;
        end
        else if (!loaded_r)
        begin
            // Config captured on the first edge out of any reset
            detect_enable_r <= cfg_r[`BMC_BIT_DET_EN]; // see R1, R4
            drop_reset_enable_r <= cfg_r[`BMC_BIT_RST_EN]; // see R3, R4
        end
        else
        begin
            if (wr_pmc)
            begin
                detect_enable_r <= wdata[`BMC_BIT_DET_EN]; // see R5
                drop_reset_enable_r <= wdata[`BMC_BIT_RST_EN]; // see R6
                low_power_sampling_enable_r <= wdata[`BMC_BIT_LP];
            end
            if (wr && (addr == `BMC_ADDR_IEN))
            begin
                supply_monitor_irq_enable_r <= wdata[`BMC_BIT_MON_IE];
                global_irq_enable_r <= wdata[`BMC_BIT_GLB_IE];
            end
        end
    end

    // Marks the one edge after reset release on which config is loaded
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            loaded_r <= 1'b0;
        else
            loaded_r <= 1'b1;
    end

    // Crossing flag: set wins over a software clear
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            crossing_flag_r <= 1'b0;
        else if (!detect_on)
            crossing_flag_r <= 1'b0; // see R18
        else if (fell | rose)
            crossing_flag_r <= 1'b1; // see R7, R17
        else if (wr_pmc && !wdata[`BMC_BIT_FLAG])
            crossing_flag_r <= 1'b0; // see R9, R15
    end

    // Reset request and a cause marker, both cleared by the warm reset
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            drop_reset_r <= 1'b0;
            pending_cause_r <= 1'b0;
        end
        else
        begin
            drop_reset_r <= drop_reset_enable_r & below_r; // see R6
            pending_cause_r <= drop_reset_enable_r & below_r; // see R19
        end
    end

    assign irq = crossing_flag_r & supply_monitor_irq_enable_r
                 & global_irq_enable_r; // see R8

    // Register read, data one cycle after the strobe
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            rdata <= 8'h00;
        else if (rd)
        begin
            case (addr)
                `BMC_ADDR_PMC_W:
                    // Gated so a just-disabled monitor never reads set
                    rdata <= {detect_enable_r, 2'b00, drop_reset_enable_r,
                              crossing_flag_r & detect_on,
                              low_power_sampling_enable_r,
                              1'b0, below_r & detect_on}; // see R12, R18
                `BMC_ADDR_POWER_CONTROL_W:
                    rdata <= {3'b000, cold_start_flag_r, 4'h0};
                `BMC_ADDR_CFG:
                    rdata <= cfg_r; // see R3
                `BMC_ADDR_RCR:
                    rdata <= {5'b00000, drop_reset_cause_flag_r, 2'b00};
                `BMC_ADDR_IEN:
                    rdata <= {global_irq_enable_r, 4'h0,
                              supply_monitor_irq_enable_r, 2'b00};
                default:
                    rdata <= 8'h00;
            endcase
        end
        else
            rdata <= 8'h00;
    end
endmodule // bmc_top
`default_nettype wire

// >>> tb/bmc_supply_model.sv
`timescale 1ns/1ps
`default_nettype none
module bmc_supply_model (
    input wire logic [15:0] supply_mv,
    input wire logic [1:0] threshold_sel,
    input wire logic cmp_enable,
    output logic cmp_below
);
    logic [15:0] thr_mv;
    // Trip point in mV, ascending with the select code
    always_comb
    begin
        case (threshold_sel)
            2'h0: thr_mv = 16'h0898;
            2'h1: thr_mv = 16'h0a8c;
            2'h2: thr_mv = 16'h0ed8;
            default: thr_mv = 16'h1194;
        endcase
    end
    // A stopped comparator reports a good supply
    assign cmp_below = cmp_enable && (supply_mv < thr_mv);
endmodule // bmc_supply_model
`default_nettype wire

// >>> tb/bmc_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "bmc_defines.vh"
module bmc_top_asserts #(
    parameter LP_TICK_CYCLES = 2,
    parameter LP_TICKS = 4
) (
    input wire clk,
    input wire nrst,
    input wire por_n,
    input wire [7:0] addr,
    input wire [7:0] wdata,
    input wire wr,
    input wire rd,
    input wire [7:0] rdata,
    input wire cmp_below,
    input wire [1:0] threshold_sel,
    input wire cmp_enable,
    input wire lp_osc_enable,
    input wire irq,
    input wire drop_reset_r
);
    // Decoded writes, so the properties stay short
    wire pmc_wr = wr && addr == `BMC_ADDR_PMC_W;
    wire ien_wr = wr && addr == `BMC_ADDR_IEN;
    wire cfg_wr = wr && addr == `BMC_ADDR_CFG;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    property p_thr;
        cfg_wr |=> threshold_sel == $past(wdata[6:5]);
    endproperty
    a_thr: assert property (p_thr)
        else $error("threshold select not taken from write");
    property p_det_off;
        pmc_wr && !wdata[7] |=> !cmp_enable;
    endproperty
    a_det_off: assert property (p_det_off)
        else $error("detection still on after disable");
    property p_det_on;
        pmc_wr && wdata[7] |=> cmp_enable;
    endproperty
    a_det_on: assert property (p_det_on)
        else $error("detection not on after enable");
    property p_lp_dep;
        lp_osc_enable |-> cmp_enable;
    endproperty
    a_lp_dep: assert property (p_lp_dep)
        else $error("sampling timer runs with detection off");
    property p_lp_on;
        pmc_wr && wdata[7] && wdata[2] |=> lp_osc_enable;
    endproperty
    a_lp_on: assert property (p_lp_on)
        else $error("sampling timer not started");
    property p_rst_off;
        pmc_wr && !wdata[4] |-> ##2 !drop_reset_r;
    endproperty
    a_rst_off: assert property (p_rst_off)
        else $error("drop reset while reset disabled");
    property p_irq_off;
        ien_wr && !(wdata[7] && wdata[2]) |=> !irq;
    endproperty
    a_irq_off: assert property (p_irq_off)
        else $error("interrupt with an enable clear");
    property p_bos_off;
        rd && addr == `BMC_ADDR_PMC_W && !cmp_enable |=> !rdata[0];
    endproperty
    a_bos_off: assert property (p_bos_off)
        else $error("status set while detection off");
endmodule // bmc_top_asserts
bind bmc_top bmc_top_asserts #(.LP_TICK_CYCLES(LP_TICK_CYCLES),
    .LP_TICKS(LP_TICKS)) u_chk (.clk(clk), .nrst(nrst), .por_n(por_n),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .cmp_below(cmp_below), .threshold_sel(threshold_sel),
    .cmp_enable(cmp_enable), .lp_osc_enable(lp_osc_enable), .irq(irq),
    .drop_reset_r(drop_reset_r));
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "bmc_defines.vh"
module testbench;
    logic clk = 0, nrst = 0, por_n = 0, wr = 0, rd = 0, cmp_below;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    logic [1:0] thr;
    logic cen, lpe, irq, drst;
    logic [15:0] mv = 16'h1388;
    logic [15:0] tbl [4] = '{16'h0898, 16'h0a8c, 16'h0ed8, 16'h1194};
    int n_mismatch = 0, check_count = 0;
    // Short sampling period keeps the low-power case quick
    bmc_top #(.LP_TICK_CYCLES(2), .LP_TICKS(4)) DUT (.clk(clk),
        .nrst(nrst), .por_n(por_n), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .cmp_below(cmp_below),
        .threshold_sel(thr), .cmp_enable(cen), .lp_osc_enable(lpe),
        .irq(irq), .drop_reset_r(drst));
    bmc_supply_model PM (.supply_mv(mv), .threshold_sel(thr),
        .cmp_enable(cen), .cmp_below(cmp_below));
    initial
    begin
        forever #50 clk = ~clk;
    end
    task chk(input string n, input logic [7:0] e, g);
        check_count++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    task wr_reg(input logic [7:0] a, d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(negedge clk);
    endtask
    // Data stands only in the cycle after the strobe
    task rc(input logic [7:0] a, m, e, input string n);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(n, e, rdata & m);
    endtask
    task rst(input logic p);
        @(posedge clk);
        nrst <= 1'b0;
        por_n <= !p;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        por_n <= 1'b1;
    endtask
    task t_por;
        rc(`BMC_ADDR_CFG, 8'hf0, 8'hf0, "cfg");
        chk("thr", 8'h03, {6'h0, thr});
        rc(`BMC_ADDR_PMC_W, 8'h90, 8'h90, "pmc");
        rc(`BMC_ADDR_POWER_CONTROL_W, 8'h10, 8'h10, "cold");
        rc(`BMC_ADDR_RCR, 8'h04, 8'h00, "cause");
        wr_reg(`BMC_ADDR_POWER_CONTROL_W, 8'h00);
        rst(1'b0);
        rc(`BMC_ADDR_POWER_CONTROL_W, 8'h10, 8'h00, "warm");
        $display("test por done");
    endtask
    task t_thr;
        wr_reg(`BMC_ADDR_PMC_W, 8'h80);
        for (int c = 0; c < 4; c++)
        begin
            wr_reg(`BMC_ADDR_CFG, {1'b1, c[1:0], 5'h10});
            chk("thr", {6'h0, c[1:0]}, {6'h0, thr});
            mv <= tbl[c] - 16'h0001;
            repeat (5) @(posedge clk);
            rc(`BMC_ADDR_PMC_W, 8'h01, 8'h01, "low");
            mv <= tbl[c];
            repeat (5) @(posedge clk);
            rc(`BMC_ADDR_PMC_W, 8'h01, 8'h00, "high");
        end
        $display("test thresholds done");
    endtask
    task t_flag;
        wr_reg(`BMC_ADDR_IEN, 8'h84);
        wr_reg(`BMC_ADDR_PMC_W, 8'h80);
        rc(`BMC_ADDR_PMC_W, 8'h08, 8'h00, "clr");
        mv <= 16'h0fa0;
        repeat (5) @(posedge clk);
        rc(`BMC_ADDR_PMC_W, 8'h09, 8'h09, "fall");
        chk("irq", 8'h01, {7'h0, irq});
        wr_reg(`BMC_ADDR_PMC_W, 8'h80);
        repeat (5) @(posedge clk);
        rc(`BMC_ADDR_PMC_W, 8'h08, 8'h00, "again");
        wr_reg(`BMC_ADDR_IEN, 8'h04);
        mv <= 16'h1388;
        repeat (5) @(posedge clk);
        rc(`BMC_ADDR_PMC_W, 8'h09, 8'h08, "rise");
        chk("irq", 8'h00, {7'h0, irq});
        $display("test flag done");
    endtask
    task t_drop;
        wr_reg(`BMC_ADDR_PMC_W, 8'h90);
        mv <= 16'h0fa0;
        repeat (5) @(posedge clk);
        chk("drop", 8'h01, {7'h0, drst});
        mv <= 16'h1388;
        rst(1'b0);
        rc(`BMC_ADDR_RCR, 8'h04, 8'h04, "cause");
        rc(`BMC_ADDR_PMC_W, 8'h90, 8'h90, "reload");
        $display("test drop done");
    endtask
    task t_off;
        wr_reg(`BMC_ADDR_PMC_W, 8'h14);
        mv <= 16'h0fa0;
        repeat (5) @(posedge clk);
        rc(`BMC_ADDR_PMC_W, 8'h09, 8'h00, "off");
        chk("lp", 8'h00, {7'h0, lpe});
        chk("drop", 8'h00, {7'h0, drst});
        wr_reg(`BMC_ADDR_PMC_W, 8'h84);
        chk("lp", 8'h01, {7'h0, lpe});
        repeat (20) @(posedge clk);
        rc(`BMC_ADDR_PMC_W, 8'h01, 8'h01, "lpst");
        $display("test off done");
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Watchdog well beyond the few hundred cycles the tests take
    initial
    begin
        #500000;
        n_mismatch++;
        finish_test;
    end
    initial
    begin
        rst(1'b1);
        t_por;
        t_thr;
        t_flag;
        t_drop;
        t_off;
        finish_test;
    end
endmodule // testbench
`default_nettype wire
